// >>> bench/psau_asserts.sv
// Purpose: port checks for psau_top
// Assumes: one clock, sync reset
// Notes:   decode outputs are combinational, checked in-cycle
`timescale 1ns/10ps
module psau_asserts
(
  // clock and reset
  input wire        mclk,
  input wire        srst,
  // requests
  input wire        table_req,
  input wire        data_req,
  input wire        data_we,
  input wire        fetch_req,
  input wire        pc_load,
  input wire [15:0] table_ea,
  input wire [15:0] data_ea,
  // state and results
  input wire [7:0]  table_page,
  input wire [7:0]  remap_page,
  input wire [15:0] core_control,
  input wire [23:0] pc,
  input wire [23:0] prog_addr,
  input wire [15:0] dmem_addr,
  input wire        dmem_req,
  input wire        cfg_space,
  input wire        stall,
  input wire        rdata_valid,
  input wire        remap_write_err
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // remap is decoded only when no table op holds the path
  wire remap = data_req && data_ea[15] && core_control[2] && !table_req;

  chk_tbl_addr: assert property (table_req |-> prog_addr == {table_page, table_ea})
    else $error("table address wrong");
  chk_cfg_sel: assert property (table_req |-> cfg_space == table_page[7])
    else $error("space select wrong");
  chk_remap_addr: assert property (stall |-> prog_addr == {1'b0, remap_page, data_ea[14:1], 1'b0})
    else $error("remap address wrong");
  chk_stall_len: assert property (remap && !data_we && !$past(stall) |-> stall ##1 !stall ##1 rdata_valid)
    else $error("remap read timing wrong");
  chk_remap_wr: assert property (remap && data_we |=> remap_write_err)
    else $error("remap write not refused");
  chk_tbl_block: assert property (table_req |-> !stall)
    else $error("remap during table op");
  chk_dmem_pass: assert property (data_req && !table_req && !(data_ea[15] && core_control[2])
    |-> dmem_req && dmem_addr == data_ea) else $error("data access not passed");
  chk_pc_step: assert property (fetch_req && !table_req && !data_req && !pc_load
    |=> pc == $past(pc) + 24'h000002) else $error("pc step wrong");
  chk_pc_align: assert property (pc[0] == 1'b0)
    else $error("pc odd");

  cover property (table_req && cfg_space);
  cover property (stall);
  cover property (remap_write_err);
endmodule

// >>> bench/psau_pmem_model.sv
// Purpose: behavioural program memory behind psau_top
// Assumes: answer valid the cycle after the request
// Notes:   returns its last word inverted when not asked, so no word is held two cycles
`timescale 1ns/10ps
module psau_pmem_model
(
  // request from the block
  input  wire         mclk,
  input  wire         prog_req,
  input  wire         prog_we,
  input  wire         prog_we_high,
  input  wire [1:0]   prog_lane_en,
  input  wire [23:0]  prog_addr,
  input  wire [23:0]  prog_wdata,
  // answer
  output logic [23:0] prog_rdata
);
  logic [23:0] mem [int];
  logic [23:0] w;
  int          a;
  initial prog_rdata = 24'h000000;
  // 24-bit words keyed by even address, byte select ignored
  always @(posedge mclk)
  begin
    a = {prog_addr[23:1], 1'b0};
    w = mem.exists(a) ? mem[a] : ~prog_addr;
    if (prog_req && !prog_we)
      prog_rdata <= w;
    else
      prog_rdata <= ~prog_rdata;
    if (prog_we_high)
      w[23:16] = prog_wdata[23:16];
    if (!prog_we_high && prog_lane_en[0])
      w[7:0] = prog_wdata[7:0];
    if (!prog_we_high && prog_lane_en[1])
      w[15:8] = prog_wdata[15:8];
    if (prog_req && prog_we)
      mem[a] = w;
  end
endmodule

// >>> bench/tb.sv
// Purpose: self-checking bench for psau_top
// Assumes: inputs change on the falling edge
// Notes:   memory words are preloaded so expectations are fixed
`timescale 1ns/10ps
module tb;
  logic        mclk, srst, table_page_we, remap_page_we, core_control_we;
  logic        fetch_req, pc_load, table_req, table_byte, data_req, data_we;
  logic [1:0]  table_op;
  logic [15:0] reg_wdata, table_ea, table_wdata, data_ea, data_wdata;
  logic [23:0] pc_load_val;
  wire  [7:0]  table_page, remap_page;
  wire  [15:0] core_control, dmem_addr, dmem_wdata, rdata;
  wire  [23:0] pc, prog_addr, prog_wdata, prog_rdata;
  wire  [1:0]  prog_lane_en;
  wire         prog_req, prog_we, prog_we_high, dmem_req, dmem_we, stall;
  wire         rdata_valid, remap_write_err, cfg_space;
  int          bad_count, n_checks;

  psau_top u_dut
  (
    .mclk            (mclk),
    .srst            (srst),
    .table_page_we   (table_page_we),
    .remap_page_we   (remap_page_we),
    .core_control_we (core_control_we),
    .reg_wdata       (reg_wdata),
    .table_page      (table_page),
    .remap_page      (remap_page),
    .core_control    (core_control),
    .fetch_req       (fetch_req),
    .pc_load         (pc_load),
    .pc_load_val     (pc_load_val),
    .pc              (pc),
    .table_req       (table_req),
    .table_op        (table_op),
    .table_byte      (table_byte),
    .table_ea        (table_ea),
    .table_wdata     (table_wdata),
    .data_req        (data_req),
    .data_we         (data_we),
    .data_ea         (data_ea),
    .data_wdata      (data_wdata),
    .prog_req        (prog_req),
    .prog_we         (prog_we),
    .prog_we_high    (prog_we_high),
    .prog_addr       (prog_addr),
    .prog_wdata      (prog_wdata),
    .prog_lane_en    (prog_lane_en),
    .prog_rdata      (prog_rdata),
    .dmem_req        (dmem_req),
    .dmem_we         (dmem_we),
    .dmem_addr       (dmem_addr),
    .dmem_wdata      (dmem_wdata),
    .stall           (stall),
    .rdata_valid     (rdata_valid),
    .rdata           (rdata),
    .remap_write_err (remap_write_err),
    .cfg_space       (cfg_space)
  );

  psau_pmem_model u_pm
  (
    .mclk         (mclk),
    .prog_req     (prog_req),
    .prog_we      (prog_we),
    .prog_we_high (prog_we_high),
    .prog_lane_en (prog_lane_en),
    .prog_addr    (prog_addr),
    .prog_wdata   (prog_wdata),
    .prog_rdata   (prog_rdata)
  );

  always #10 mclk = ~mclk;

  task automatic chk(input string nm, input logic [23:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // sel: table page, remap page, control
  task automatic wr_reg(input [2:0] sel, input [15:0] v);
    @(negedge mclk);
    {table_page_we, remap_page_we, core_control_we, reg_wdata} = {sel, v};
    @(negedge mclk);
    {table_page_we, remap_page_we, core_control_we} = 3'h0;
  endtask

  // one table op; exp is {valid, data} seen two cycles later
  task automatic tbl(input [1:0] op, input b, input [7:0] pg, input [15:0] ea, wd, input [23:0] exp);
    @(negedge mclk);
    {table_req, table_op, table_byte, table_ea, table_wdata} = {1'b1, op, b, ea, wd};
    #1;
    chk("paddr", prog_addr, {pg, ea});
    chk("cfg", cfg_space, pg[7]);
    chk("lanes", prog_lane_en, b ? (ea[0] ? 24'h000002 : 24'h000001) : 24'h000003);
    if (op[1])
      chk("wr", {prog_we, prog_we_high, op[0] ? prog_wdata[23:16] : prog_wdata[15:0]}, {1'b1, op[0], wd});
    @(negedge mclk);
    table_req = 1'b0;
    @(negedge mclk);
    if (!op[1])
      chk("rd", {rdata_valid, rdata}, exp);
  endtask

  task automatic t_regs;
    chk("pc rst", pc, 24'h000000);
    wr_reg(3'h4, 16'h0081);
    wr_reg(3'h2, 16'h00B2);
    wr_reg(3'h1, 16'h0004);
    chk("pages", {table_page, remap_page}, 24'h0081B2);
    chk("ctrl", core_control, 24'h000004);
    $display("t_regs done");
  endtask

  // every read lane case, configuration page, odd addresses too
  task automatic t_tbl_rd;
    u_pm.mem[24'h819234] = 24'hC3A55A;
    tbl(2'h0, 1'b0, 8'h81, 16'h9234, 16'h0000, 24'h01A55A);
    tbl(2'h0, 1'b1, 8'h81, 16'h9235, 16'h0000, 24'h0100A5);
    tbl(2'h0, 1'b1, 8'h81, 16'h9234, 16'h0000, 24'h01005A);
    tbl(2'h1, 1'b0, 8'h81, 16'h9234, 16'h0000, 24'h0100C3);
    tbl(2'h1, 1'b1, 8'h81, 16'h9235, 16'h0000, 24'h010000);
    tbl(2'h1, 1'b1, 8'h81, 16'h9234, 16'h0000, 24'h0100C3);
    $display("t_tbl_rd done");
  endtask

  task automatic t_tbl_wr;
    wr_reg(3'h4, 16'h0001);
    tbl(2'h2, 1'b0, 8'h01, 16'h0010, 16'h1234, 24'h000000);
    tbl(2'h3, 1'b1, 8'h01, 16'h0010, 16'h0077, 24'h000000);
    tbl(2'h0, 1'b0, 8'h01, 16'h0010, 16'h0000, 24'h011234);
    tbl(2'h1, 1'b0, 8'h01, 16'h0010, 16'h0000, 24'h010077);
    $display("t_tbl_wr done");
  endtask

  // page bit 0 clear while ea bit 15 set shows the bit source
  task automatic t_remap;
    u_pm.mem[24'h594566] = 24'hFF8421;
    @(negedge mclk);
    {data_req, data_we, data_ea} = {2'b10, 16'hC567};
    #1;
    chk("raddr", prog_addr, 24'h594566);
    chk("stall", stall, 24'h000001);
    @(negedge mclk);
    chk("stall1", stall, 24'h000000);
    @(negedge mclk);
    data_req = 1'b0;
    chk("rrd", {rdata_valid, rdata}, 24'h018421);
    @(negedge mclk);
    {data_req, data_we} = 2'b11;
    #1;
    chk("no wr", {prog_req, prog_we}, 24'h000000);
    @(negedge mclk);
    {data_req, data_we} = 2'b00;
    chk("werr", remap_write_err, 24'h000001);
    wr_reg(3'h1, 16'h0000);
    {data_req, data_we, data_ea, data_wdata} = {2'b11, 16'hC567, 16'h5AA5};
    #1;
    chk("off", {stall, dmem_req, dmem_addr}, 24'h01C567);
    chk("dwr", {dmem_we, dmem_wdata}, 24'h015AA5);
    wr_reg(3'h1, 16'h0004);
    {table_req, table_op, table_ea, data_we} = {1'b1, 2'h0, 16'h0010, 1'b0};
    #1;
    chk("blk", {stall, dmem_req}, 24'h000001);
    @(negedge mclk);
    {table_req, data_req} = 2'b00;
    $display("t_remap done");
  endtask

  task automatic t_fetch;
    @(negedge mclk);
    {pc_load, pc_load_val} = {1'b1, 24'h000101};
    @(negedge mclk);
    {pc_load, fetch_req} = 2'b01;
    chk("pcld", pc, 24'h000100);
    #1;
    chk("faddr", prog_addr, 24'h000100);
    repeat (3) @(negedge mclk);
    fetch_req = 1'b0;
    chk("pcadv", pc, 24'h000106);
    $display("t_fetch done");
  endtask

  initial
  begin
    {mclk, srst, table_page_we, remap_page_we, core_control_we, fetch_req, pc_load} = 7'h20;
    {table_req, table_byte, data_req, data_we, table_op} = 6'h00;
    {reg_wdata, table_ea, table_wdata, data_ea, data_wdata, pc_load_val} = '0;
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    t_regs;
    t_tbl_rd;
    t_tbl_wr;
    t_remap;
    t_fetch;
    print_verdict;
  end

  // about 60 cycles expected; cut a hang well past that
  initial
  begin
    #20000;
    bad_count++;
    print_verdict;
  end
endmodule

bind psau_top psau_asserts u_chk
(
  .mclk            (mclk),
  .srst            (srst),
  .table_req       (table_req),
  .data_req        (data_req),
  .data_we         (data_we),
  .fetch_req       (fetch_req),
  .pc_load         (pc_load),
  .table_ea        (table_ea),
  .data_ea         (data_ea),
  .table_page      (table_page),
  .remap_page      (remap_page),
  .core_control    (core_control),
  .pc              (pc),
  .prog_addr       (prog_addr),
  .dmem_addr       (dmem_addr),
  .dmem_req        (dmem_req),
  .cfg_space       (cfg_space),
  .stall           (stall),
  .rdata_valid     (rdata_valid),
  .remap_write_err (remap_write_err)
);

// >>> logic/psau_lane_steer.v
// Purpose: steer program word lanes onto the 16-bit data result
// Assumes: byte select is the low address bit of the access
// Notes:   the phantom byte of a high read always reads zero
`timescale 1ns/10ps
module psau_lane_steer
(
  // program word and selectors
  input  wire [23:0] pword,
  input  wire        high_sel,
  input  wire        byte_mode,
  input  wire        byte_sel,
  // steered data
  output reg  [15:0] rdata
);

  // pick lanes for low and high table reads
  always @*
  begin
    rdata = 16'h0000;
    if (!high_sel)
    begin
      if (!byte_mode)
        rdata = pword[15:0];                           // RULE_13
      else if (byte_sel)
        rdata = {8'h00, pword[15:8]};                  // RULE_14
      else
        rdata = {8'h00, pword[7:0]};                   // RULE_14
    end
    else
    begin
      // phantom byte: upper data byte and odd byte read as zero
      if (!byte_mode || !byte_sel)
        rdata = {8'h00, pword[23:16]};                 // RULE_15 RULE_16
      else
        rdata = 16'h0000;                              // RULE_16
    end
  end

endmodule

// >>> logic/psau_pc_step.v
// Purpose: program counter for instruction fetch
// Assumes: one word step per fetch enable
// Notes:   step is two so program and data word addresses line up
`timescale 1ns/10ps
`include "psau_map.vh"
module psau_pc_step
(
  // clock and reset
  input  wire        mclk,
  input  wire        srst,
  // control
  input  wire        pc_load,
  input  wire [23:0] pc_load_val,
  input  wire        pc_advance,
  // count
  output wire [23:0] pc
);

  reg [23:0] pc_reg;
  reg [23:0] pc_next;

  // next value, load wins over advance
  always @*
  begin
    pc_next = pc_reg;
    if (pc_load)
      pc_next = {pc_load_val[23:1], 1'b0};
    else if (pc_advance)
      pc_next = pc_reg + `PSAU_PC_STEP;                // RULE_10
  end

  // counter register
  always @(posedge mclk)
  begin
    if (srst)
      pc_reg <= `PSAU_PC_RST;
    else
      pc_reg <= pc_next;
  end

  assign pc = pc_reg;                                  // RULE_08

endmodule

// >>> logic/psau_top.v
// Purpose: form program space addresses for fetch, table and remap accesses
// Assumes: core drives requests on mclk; program memory answers next cycle
// Notes:   page and control registers are written by the core, not a bus
//
// Notes on behaviour
// RULE_01: program space uses 24-bit word addresses and words; data uses 16 bits.
// RULE_02: table address is table page above the unmodified 16-bit effective address.
// RULE_03: table page top bit selects user (0) or configuration (1) space.
// RULE_04: remap address is remap page above effective address bits 14 to 0.
// RULE_05: the 8-bit remap page selects one 16K-word program page.
// RULE_06: remap accesses drive program address bit 23 to zero.
// RULE_07: remap ignores effective bit 15; address bit 15 comes from page bit 0.
// RULE_08: fetch and remap reads force program address bit 0 to zero.
// RULE_09: table accesses take any byte alignment and may reach configuration space.
// RULE_10: program counter advances by two per program word.
// RULE_11: low table ops reach bits 15..0; high ops alone reach bits 23..16.
// RULE_12: each table read and write selects byte or word size.
// RULE_13: word low table read returns program bits 15..0 unchanged.
// RULE_14: byte low table read returns upper byte if select is 1, else lower.
// RULE_15: word high table read returns bits 23..16 low; upper byte reads zero.
// RULE_16: byte high read returns zero for select 1, bits 23..16 for select 0.
// RULE_17: remap path is read only and returns the low 16 bits.
// RULE_18: remap acts only with control remap enable set and effective bit 15 set.
// RULE_19: a remapped read stretches the instruction by one extra cycle.
// RULE_20: remap is suspended while a table read or write is in progress.
// RULE_21: other data accesses go to data memory unchanged, no program address.
`timescale 1ns/10ps
`include "psau_map.vh"
module psau_top
(
  // clock and reset
  input  wire        mclk,
  input  wire        srst,
  // page and control register writes from the core
  input  wire        table_page_we,
  input  wire        remap_page_we,
  input  wire        core_control_we,
  input  wire [15:0] reg_wdata,
  output wire [7:0]  table_page,
  output wire [7:0]  remap_page,
  output wire [15:0] core_control,
  // instruction fetch
  input  wire        fetch_req,
  input  wire        pc_load,
  input  wire [23:0] pc_load_val,
  output wire [23:0] pc,
  // table operations
  input  wire        table_req,
  input  wire [1:0]  table_op,
  input  wire        table_byte,
  input  wire [15:0] table_ea,
  input  wire [15:0] table_wdata,
  // data space accesses
  input  wire        data_req,
  input  wire        data_we,
  input  wire [15:0] data_ea,
  input  wire [15:0] data_wdata,
  // program memory side
  output reg         prog_req,
  output reg         prog_we,
  output reg         prog_we_high,
  output reg  [23:0] prog_addr,
  output reg  [23:0] prog_wdata,
  output reg  [1:0]  prog_lane_en,
  input  wire [23:0] prog_rdata,
  // data memory side
  output reg         dmem_req,
  output reg         dmem_we,
  output reg  [15:0] dmem_addr,
  output reg  [15:0] dmem_wdata,
  // results to the core
  output reg         stall,
  output reg         rdata_valid,
  output reg  [15:0] rdata,
  output reg         remap_write_err,
  output reg         cfg_space
);

  // access kinds held for the read return
  localparam K_NONE  = 2'h0;
  localparam K_TABLE = 2'h1;
  localparam K_REMAP = 2'h2;

  // remap cycle states
  localparam S_IDLE  = 1'b0;
  localparam S_EXTRA = 1'b1;

  reg  [7:0]  table_page_reg;
  reg  [7:0]  remap_page_reg;
  reg  [15:0] core_control_reg;
  reg         state_reg;
  reg         state_next;
  reg  [1:0]  kind_reg;
  reg         high_reg;
  reg         byte_reg;
  reg         bsel_reg;
  reg         table_busy;
  reg         remap_hit;
  reg         is_write;
  wire [15:0] steered;
  wire        pc_adv;

  // page and control registers, written by the core
  always @(posedge mclk)
  begin
    if (srst)
    begin
      table_page_reg   <= `PSAU_PAGE_RST;
      remap_page_reg   <= `PSAU_PAGE_RST;
      core_control_reg <= `PSAU_CTRL_RST;
    end
    else
    begin
      if (table_page_we)
        table_page_reg <= reg_wdata[7:0];
      if (remap_page_we)
        remap_page_reg <= reg_wdata[7:0];              // RULE_05
      if (core_control_we)
        core_control_reg <= reg_wdata;
    end
  end

  assign table_page   = table_page_reg;
  assign remap_page   = remap_page_reg;
  assign core_control = core_control_reg;

  // remap decode; table work blocks it
  always @*
  begin
    table_busy = table_req;                            // RULE_20
    is_write   = table_op[1];
    remap_hit  = data_req && !table_busy &&
                 core_control_reg[`PSAU_CTRL_REMAP_BIT] &&
                 data_ea[`PSAU_EA_MSB];                // RULE_18
  end

  // pc only advances on fetches that find the memory port free
  assign pc_adv = fetch_req && !table_req && !remap_hit && !stall;

  psau_pc_step u_pc
  (
    .mclk        (mclk),
    .srst        (srst),
    .pc_load     (pc_load),
    .pc_load_val (pc_load_val),
    .pc_advance  (pc_adv),
    .pc          (pc)
  );

  // program and data memory request routing
  always @*
  begin
    prog_req     = 1'b0;
    prog_we      = 1'b0;
    prog_we_high = 1'b0;
    prog_addr    = 24'h000000;
    prog_wdata   = 24'h000000;
    prog_lane_en = 2'h0;
    dmem_req     = 1'b0;
    dmem_we      = 1'b0;
    dmem_addr    = 16'h0000;
    dmem_wdata   = 16'h0000;
    cfg_space    = 1'b0;
    if (table_req)
    begin
      prog_req  = 1'b1;
      // no alignment forcing on table addresses
      prog_addr = {table_page_reg, table_ea};          // RULE_02 RULE_09 RULE_01
      cfg_space = table_page_reg[`PSAU_TBL_CFG_BIT];   // RULE_03
      prog_we   = is_write;
      // high ops alone touch the upper byte lane
      prog_we_high = is_write && table_op[0];          // RULE_11
      if (table_op[0])
        prog_wdata = {table_wdata[7:0], 16'h0000};
      else if (table_byte)
        prog_wdata = {8'h00, table_wdata[7:0], table_wdata[7:0]};
      else
        prog_wdata = {8'h00, table_wdata};
      // byte lanes: bit 1 upper, bit 0 lower of the selected word
      if (!table_byte)
        prog_lane_en = 2'h3;                           // RULE_12
      else if (table_ea[0])
        prog_lane_en = 2'h2;
      else
        prog_lane_en = 2'h1;
    end
    else if (remap_hit && !data_we && state_reg == S_IDLE)
    begin
      prog_req  = 1'b1;
      // bit 23 held low, ea bit 15 replaced by page bit 0
      prog_addr = {1'b0, remap_page_reg, data_ea[14:1], 1'b0}; // RULE_04 RULE_06 RULE_07 RULE_08
      prog_lane_en = 2'h3;
    end
    else if (fetch_req && !remap_hit)
    begin
      prog_req  = 1'b1;
      prog_addr = pc;                                  // RULE_08
      prog_lane_en = 2'h3;
    end
    // data memory has its own port, so table work and fetches never drop it
    if (data_req && !remap_hit)
    begin
      dmem_req   = 1'b1;                               // RULE_21
      dmem_we    = data_we;
      dmem_addr  = data_ea;
      dmem_wdata = data_wdata;
    end
  end

  // remap read takes a second cycle while the fetched word returns
  always @*
  begin
    state_next = S_IDLE;
    stall      = 1'b0;
    case (state_reg)
      S_IDLE:
      begin
        if (remap_hit && !data_we)
        begin
          state_next = S_EXTRA;                        // RULE_19
          stall      = 1'b1;
        end
      end
      S_EXTRA:
      begin
        state_next = S_IDLE;
      end
      default:
      begin
        state_next = S_IDLE;
      end
    endcase
  end

  // capture access kind for the returning data
  always @(posedge mclk)
  begin
    if (srst)
    begin
      state_reg <= S_IDLE;
      kind_reg  <= K_NONE;
      high_reg  <= 1'b0;
      byte_reg  <= 1'b0;
      bsel_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      kind_reg  <= K_NONE;
      if (table_req && !is_write)
      begin
        kind_reg <= K_TABLE;
        high_reg <= table_op[0];
        byte_reg <= table_byte;
        bsel_reg <= table_ea[0];
      end
      else if (remap_hit && !data_we && state_reg == S_IDLE)
        kind_reg <= K_REMAP;
    end
  end

  psau_lane_steer u_steer
  (
    .pword     (prog_rdata),
    .high_sel  (high_reg),
    .byte_mode (byte_reg),
    .byte_sel  (bsel_reg),
    .rdata     (steered)
  );

  // registered read results and remap write refusal
  always @(posedge mclk)
  begin
    if (srst)
    begin
      rdata_valid     <= 1'b0;
      rdata           <= 16'h0000;
      remap_write_err <= 1'b0;
    end
    else
    begin
      rdata_valid     <= 1'b0;
      // writes through the remap window are dropped
      remap_write_err <= remap_hit && data_we;         // RULE_17
      if (kind_reg == K_TABLE)
      begin
        rdata_valid <= 1'b1;
        rdata       <= steered;
      end
      else if (kind_reg == K_REMAP)
      begin
        rdata_valid <= 1'b1;
        rdata       <= prog_rdata[15:0];               // RULE_17
      end
    end
  end

endmodule

// >>> pkg/psau_map.vh
// Purpose: constants for the program space access unit
// Assumes: 16-bit data space, 24-bit program words
// Notes:   widths, field positions and reset values
`ifndef PSAU_MAP_VH
`define PSAU_MAP_VH

`define PSAU_PADDR_W        24
`define PSAU_PWORD_W        24
`define PSAU_DATA_W         16
`define PSAU_PAGE_W         8
`define PSAU_EA_MSB         15
`define PSAU_TBL_CFG_BIT    7
`define PSAU_CTRL_REMAP_BIT 2
`define PSAU_CTRL_W         16
`define PSAU_PAGE_RST       8'h00
`define PSAU_CTRL_RST       16'h0000
`define PSAU_PC_STEP        24'h000002
`define PSAU_PC_RST         24'h000000

// table operation codes
`define PSAU_OP_RDL         2'h0
`define PSAU_OP_RDH         2'h1
`define PSAU_OP_WTL         2'h2
`define PSAU_OP_WTH         2'h3

`endif
